// ==== design/ctm_top.sv ====
// Purpose: compact timer, 10-bit counter with period and match compare
// Assumes: Avalon-MM slave, 8-bit registers in word slots
// Notes: wave outputs registered
// Summary of operation
// - 10-bit up-counter steps on each selected tick when on and not paused
// - period compare uses top three bits; match compare uses all ten
// - software cannot load count; its only way to clear it is a count_on rise
// - counter clears on overflow or selected compare match, flag on compare match only
// - pause bit holds count; clearing it resumes from held value
// - clk_select picks sys/4, sys, fast/16, fast/64, sub, pin edges
// - count_on low stops; rise zeroes count; fall keeps residual count
// - count_on rise restores initial output level in compare mode, inactive level (inverse of initial level bit) in PWM mode
// - period codes 1..7 give 128..896 clocks; code 0 means 1024
// - clear select zero lets period match reset the counter
// - op mode: 00 compare, 01 undefined, 10 PWM, 11 timer
// - timer mode leaves output unused while counting continues
// - compare mode match acts on output: none, low, high, toggle
// - PWM mode output: inactive, active, PWM waveform, undefined
// - match requesting current initial level gives no visible change
// - inverted pin is always the inverse of the wave pin
// - count readable as register pair; match value read/write pair
// - initial level bit: compare start level, PWM active level
// - polarity bit inverts output; no effect in timer mode
// - swap bit exchanges period and duty compare in PWM mode
// - clear source: 0 period or overflow, 1 match or overflow; ignored in PWM
`timescale 1ns/1ps
`default_nettype none
module ctm_top
  import ctm_pkg::*;
#(
  parameter int CNT_W = CTM_CNT_W
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic FAST_CLK_STB,
  input wire logic SUB_CLK_STB,
  input wire logic EXT_COUNT_CLOCK_PIN,
  output logic WAVE_OUT_PIN,
  output logic WAVE_OUT_INVERTED_PIN,
  output logic PERIOD_IRQ,
  output logic MATCH_IRQ
);
  initial begin
    if (CNT_W != 10) begin
      $error("counter width must be 10");
    end
  end
  ctm_tick_if tk();
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic [9:0] match_q;
  logic on_q;
  logic out_q;
  logic out_d;
  logic [31:0] rdata_q;
  logic wait_q;
  ctm_bus_type bus_q;
  logic per_irq_q;
  logic mat_irq_q;
  logic run;
  logic on_rise;
  logic [2:0] per;
  logic [1:0] mode;
  logic [1:0] ofn;
  logic init_lv;
  logic pol;
  logic swap;
  logic clr_sel;
  logic per_hit;
  logic mat_hit;
  logic ovf;
  logic clr;
  logic wr_go;
  logic rd_go;
  logic [7:0] rd_byte;
  logic pwm_lv;
  assign tk.sel = ctl0_q[CTM_CKSEL_LSB +: 3];
  assign per = ctl0_q[CTM_PER_LSB +: 3];
  assign mode = ctl1_q[CTM_MODE_LSB +: 2];
  assign ofn = ctl1_q[CTM_OFN_LSB +: 2];
  assign init_lv = ctl1_q[CTM_INIT_BIT];
  assign pol = ctl1_q[CTM_POL_BIT];
  assign swap = ctl1_q[CTM_SWAP_BIT];
  assign clr_sel = ctl1_q[CTM_CLR_BIT];
  ctm_clksel u_clksel (
    .clk(CLK),
    .rst(RST),
    .fast_stb(FAST_CLK_STB),
    .sub_stb(SUB_CLK_STB),
    .ext_pin(EXT_COUNT_CLOCK_PIN),
    .tk(tk)
  );
  // bus handshake: one wait cycle then acknowledge
  assign wr_go = AVS_WRITE && (bus_q == CTM_BUS_ACK);
  assign rd_go = AVS_READ && (bus_q == CTM_BUS_ACK);
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_q <= CTM_BUS_IDLE;
      wait_q <= 1'b1;
    end else if (bus_q == CTM_BUS_IDLE && (AVS_READ || AVS_WRITE)) begin
      bus_q <= CTM_BUS_ACK;
      wait_q <= 1'b0;
    end else begin
      bus_q <= CTM_BUS_IDLE;
      wait_q <= 1'b1;
    end
  end
  always_comb begin
    rd_byte = 8'h00;
    unique case (AVS_ADDRESS)
      5'(CTM_OFF_CTL0): rd_byte = ctl0_q;
      5'(CTM_OFF_CTL1): rd_byte = ctl1_q;
      5'(CTM_OFF_CNTL): rd_byte = cnt_q[7:0];
      5'(CTM_OFF_CNTH): rd_byte = {6'h00, cnt_q[9:8]};
      CTM_OFF_MATL: rd_byte = match_q[7:0];
      CTM_OFF_MATH: rd_byte = {6'h00, match_q[9:8]};
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= 32'h00000000;
    end else if (AVS_READ && bus_q == CTM_BUS_IDLE) begin
      rdata_q <= {24'h000000, rd_byte};
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctl0_q <= CTM_CTL0_RST;
      ctl1_q <= CTM_CTL1_RST;
      match_q <= 10'h000;
    end else if (wr_go && AVS_BYTEENABLE[0]) begin
      if (AVS_ADDRESS == 5'(CTM_OFF_CTL0)) begin
        ctl0_q <= AVS_WRITEDATA[7:0];
      end
      if (AVS_ADDRESS == 5'(CTM_OFF_CTL1)) begin
        ctl1_q <= AVS_WRITEDATA[7:0];
      end
      if (AVS_ADDRESS == CTM_OFF_MATL) begin
        match_q[7:0] <= AVS_WRITEDATA[7:0];
      end
      if (AVS_ADDRESS == CTM_OFF_MATH) begin
        match_q[9:8] <= AVS_WRITEDATA[1:0];
      end
    end
  end
  // counter core
  always_ff @(posedge CLK) begin
    if (RST) begin
      on_q <= 1'b0;
    end else begin
      on_q <= ctl0_q[CTM_ON_BIT];
    end
  end
  assign on_rise = ctl0_q[CTM_ON_BIT] && !on_q;
  assign run = on_q && ctl0_q[CTM_ON_BIT] && !ctl0_q[CTM_PAUSE_BIT] && tk.tick;
  assign per_hit = run && (per != 3'h0) && (cnt_q[9:7] == per - 3'h1)
    && (cnt_q[6:0] == 7'h7F);
  assign mat_hit = run && (match_q != 10'h000) && (cnt_q == match_q - 10'h001);
  assign ovf = run && (cnt_q == 10'h3FF);
  always_comb begin
    if (mode == CTM_MODE_PWM) begin
      clr = swap ? mat_hit : (per_hit || ovf);
    end else if (clr_sel) begin
      clr = mat_hit || ovf;
    end else begin
      clr = per_hit || ovf;
    end
  end
  always_comb begin
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = 10'h000;
    end else if (clr) begin
      cnt_d = 10'h000;
    end else if (run) begin
      cnt_d = cnt_q + 10'h001;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      per_irq_q <= 1'b0;
      mat_irq_q <= 1'b0;
    end else begin
      per_irq_q <= per_hit && !(clr_sel && mode != CTM_MODE_PWM);
      mat_irq_q <= mat_hit;
    end
  end
  // waveform output
  assign pwm_lv = swap ? (cnt_q[9:7] < per) : (cnt_q < match_q);
  always_comb begin
    out_d = out_q;
    if (on_rise) begin
      out_d = (mode == CTM_MODE_PWM) ? !init_lv : init_lv;
    end else if (mode == CTM_MODE_CMP && mat_hit) begin
      unique case (ofn)
        2'h0: out_d = out_q;
        2'h1: out_d = 1'b0;
        2'h2: out_d = 1'b1;
        2'h3: out_d = !out_q;
      endcase
    end else if (mode == CTM_MODE_PWM) begin
      unique case (ofn)
        2'h0: out_d = !init_lv;
        2'h1: out_d = init_lv;
        2'h2: out_d = on_q ? (pwm_lv ? init_lv : !init_lv) : out_q;
        2'h3: out_d = out_q;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      WAVE_OUT_PIN <= 1'b0;
      WAVE_OUT_INVERTED_PIN <= 1'b1;
    end else if (mode == CTM_MODE_TMR) begin
      WAVE_OUT_PIN <= out_d;
      WAVE_OUT_INVERTED_PIN <= !out_d;
    end else begin
      WAVE_OUT_PIN <= out_d ^ pol;
      WAVE_OUT_INVERTED_PIN <= !(out_d ^ pol);
    end
  end
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign PERIOD_IRQ = per_irq_q;
  assign MATCH_IRQ = mat_irq_q;
  // checks: inverted pin and counter
  a_inv_pin: assert property (@(posedge CLK) disable iff (RST)
    WAVE_OUT_INVERTED_PIN == !WAVE_OUT_PIN) else $error("inverted pin mismatch");
  a_on_clear: assert property (@(posedge CLK) disable iff (RST)
    on_rise |=> cnt_q == 10'h000) else $error("count not cleared on start");
  a_pause_hold: assert property (@(posedge CLK) disable iff (RST)
    ctl0_q[CTM_PAUSE_BIT] && !on_rise |=> $stable(cnt_q)) else $error("count moved in pause");
  a_off_hold: assert property (@(posedge CLK) disable iff (RST)
    !ctl0_q[CTM_ON_BIT] |=> $stable(cnt_q)) else $error("count moved while off");
  a_step_one: assert property (@(posedge CLK) disable iff (RST)
    run && !clr && !on_rise |=> cnt_q == $past(cnt_q) + 10'h001) else $error("bad step");
  a_ovf_wrap: assert property (@(posedge CLK) disable iff (RST)
    ovf && !on_rise |=> cnt_q == 10'h000) else $error("no wrap on overflow");
  a_cnt_still: assert property (@(posedge CLK) disable iff (RST)
    !run && !on_rise |=> $stable(cnt_q)) else $error("count moved without tick");
  // checks: comparators and flags
  a_per_clear: assert property (@(posedge CLK) disable iff (RST)
    per_hit && !clr_sel && mode != CTM_MODE_PWM |=> cnt_q == 10'h000 ##1 PERIOD_IRQ == 1'b0)
    else $error("period match did not clear");
  a_per_point: assert property (@(posedge CLK) disable iff (RST)
    per_hit |-> cnt_q + 10'h001 == {per, 7'h00}) else $error("period match at wrong count");
  a_per_zero: assert property (@(posedge CLK) disable iff (RST)
    per == 3'h0 |-> !per_hit) else $error("period match with code zero");
  a_per_flag: assert property (@(posedge CLK) disable iff (RST)
    per_hit && !clr_sel && mode != CTM_MODE_PWM |=> PERIOD_IRQ)
    else $error("period flag missing");
  a_per_mute: assert property (@(posedge CLK) disable iff (RST)
    per_hit && clr_sel && mode != CTM_MODE_PWM |=> !PERIOD_IRQ)
    else $error("period flag while match clears");
  a_per_pulse: assert property (@(posedge CLK) disable iff (RST)
    PERIOD_IRQ |=> !PERIOD_IRQ) else $error("period flag longer than one clock");
  a_mat_point: assert property (@(posedge CLK) disable iff (RST)
    mat_hit |-> cnt_q + 10'h001 == match_q) else $error("match at wrong count");
  a_mat_zero: assert property (@(posedge CLK) disable iff (RST)
    match_q == 10'h000 |-> !mat_hit) else $error("match with value zero");
  a_mat_clear: assert property (@(posedge CLK) disable iff (RST)
    mat_hit && clr_sel && mode != CTM_MODE_PWM |=> cnt_q == 10'h000)
    else $error("match did not clear");
  a_swap_clear: assert property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_PWM && swap && mat_hit |=> cnt_q == 10'h000)
    else $error("swapped period did not clear");
  a_irq_pulse: assert property (@(posedge CLK) disable iff (RST)
    MATCH_IRQ && !mat_hit |=> !MATCH_IRQ) else $error("match flag longer than one clock");
  a_mat_flag: assert property (@(posedge CLK) disable iff (RST)
    mat_hit |=> MATCH_IRQ) else $error("match flag missing");
  a_mat_src: assert property (@(posedge CLK) disable iff (RST)
    MATCH_IRQ |-> $past(mat_hit)) else $error("match flag without match");
  // checks: waveform output
  a_out_init: assert property (@(posedge CLK) disable iff (RST)
    on_rise && mode == CTM_MODE_CMP |=> out_q == $past(init_lv)) else $error("bad init");
  a_pwm_start: assert property (@(posedge CLK) disable iff (RST)
    on_rise && mode == CTM_MODE_PWM |=> out_q == !$past(init_lv)) else $error("bad pwm start");
  a_cmp_low: assert property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_CMP && mat_hit && ofn == 2'h1 |=> !out_q) else $error("output not low");
  a_cmp_high: assert property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_CMP && mat_hit && ofn == 2'h2 |=> out_q) else $error("output not high");
  a_cmp_toggle: assert property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_CMP && mat_hit && ofn == 2'h3 |=> out_q != $past(out_q))
    else $error("output not toggled");
  a_cmp_keep: assert property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_CMP && mat_hit && ofn == 2'h0 |=> $stable(out_q)) else $error("output moved");
  a_pwm_idle: assert property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_PWM && ofn == 2'h0 |=> out_q == !$past(init_lv))
    else $error("pwm not inactive");
  a_pwm_force: assert property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_PWM && ofn == 2'h1 && !on_rise |=> out_q == $past(init_lv))
    else $error("pwm not active");
  a_pol_apply: assert property (@(posedge CLK) disable iff (RST)
    mode != CTM_MODE_TMR |=> WAVE_OUT_PIN == (out_q ^ $past(pol)))
    else $error("polarity not applied");
  a_tmr_nopol: assert property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_TMR |=> WAVE_OUT_PIN == out_q) else $error("polarity used in timer mode");
  // checks: register bus
  a_bus_ack: assert property (@(posedge CLK) disable iff (RST)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[0:1] !AVS_WAITREQUEST)
    else $error("bus not answered");
  a_bus_once: assert property (@(posedge CLK) disable iff (RST)
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("answer longer than one cycle");
  a_rd_upper: assert property (@(posedge CLK) disable iff (RST)
    AVS_READDATA[31:8] == 24'h000000) else $error("upper read bits set");
  // scenario covers
  c_per_hit: cover property (@(posedge CLK) disable iff (RST) per_hit);
  c_mat_toggle: cover property (@(posedge CLK) disable iff (RST)
    mat_hit && mode == CTM_MODE_CMP && ofn == 2'h3);
  c_pwm_run: cover property (@(posedge CLK) disable iff (RST) mode == CTM_MODE_PWM && run);
  c_ovf: cover property (@(posedge CLK) disable iff (RST) ovf);
  c_swap_clr: cover property (@(posedge CLK) disable iff (RST)
    mode == CTM_MODE_PWM && swap && mat_hit);
endmodule
`default_nettype wire

// ==== design/ctm_pkg.sv ====
// Purpose: shared constants for the compact timer
// Assumes: 8-bit registers, one per aligned 32-bit word
// Notes: offsets are byte addresses on the register bus
package ctm_pkg;
  localparam int CTM_CNT_W = 10;
  localparam logic [3:0] CTM_OFF_CTL0 = 4'h0;
  localparam logic [3:0] CTM_OFF_CTL1 = 4'h4;
  localparam logic [3:0] CTM_OFF_CNTL = 4'h8;
  localparam logic [3:0] CTM_OFF_CNTH = 4'hC;
  localparam logic [4:0] CTM_OFF_MATL = 5'h10;
  localparam logic [4:0] CTM_OFF_MATH = 5'h14;
  localparam logic [7:0] CTM_CTL0_RST = 8'h00;
  localparam logic [7:0] CTM_CTL1_RST = 8'h00;
  localparam int CTM_PAUSE_BIT = 7;
  localparam int CTM_CKSEL_LSB = 4;
  localparam int CTM_ON_BIT = 3;
  localparam int CTM_PER_LSB = 0;
  localparam int CTM_MODE_LSB = 6;
  localparam int CTM_OFN_LSB = 4;
  localparam int CTM_INIT_BIT = 3;
  localparam int CTM_POL_BIT = 2;
  localparam int CTM_SWAP_BIT = 1;
  localparam int CTM_CLR_BIT = 0;
  localparam logic [1:0] CTM_MODE_CMP = 2'h0;
  localparam logic [1:0] CTM_MODE_PWM = 2'h2;
  localparam logic [1:0] CTM_MODE_TMR = 2'h3;
  localparam int CTM_DIV_SYS4 = 4;
  localparam int CTM_DIV_H16 = 16;
  localparam int CTM_DIV_H64 = 64;
  typedef enum logic [1:0] {CTM_BUS_IDLE, CTM_BUS_ACK} ctm_bus_type;
endpackage

// ==== design/ctm_tick_if.sv ====
// Purpose: carries count ticks from the clock selector
// Assumes: one tick is one counter clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface ctm_tick_if;
  logic [2:0] sel;
  logic tick;
  modport src (input sel, output tick);
  modport dst (output sel, input tick);
endinterface
`default_nettype wire

// ==== design/ctm_clksel.sv ====
// Purpose: counter clock tick generator
// Assumes: sub and fast clocks arrive as synchronous enable strobes
// Notes: external pin edges detected on the system clock
`timescale 1ns/1ps
`default_nettype none
module ctm_clksel
  import ctm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fast_stb,
  input wire logic sub_stb,
  input wire logic ext_pin,
  ctm_tick_if.src tk
);
  logic [5:0] sys_div_q;
  logic [5:0] h_div_q;
  logic ext_q;
  logic t;
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_div_q <= 6'h00;
    end else begin
      sys_div_q <= sys_div_q + 6'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      h_div_q <= 6'h00;
    end else if (fast_stb) begin
      h_div_q <= h_div_q + 6'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_pin;
    end
  end
  always_comb begin
    unique case (tk.sel)
      3'h0: t = (sys_div_q[1:0] == 2'(CTM_DIV_SYS4 - 1));
      3'h1: t = 1'b1;
      3'h2: t = fast_stb && (h_div_q[3:0] == 4'(CTM_DIV_H16 - 1));
      3'h3: t = fast_stb && (h_div_q == 6'(CTM_DIV_H64 - 1));
      3'h4, 3'h5: t = sub_stb;
      3'h6: t = ext_pin && !ext_q;
      3'h7: t = !ext_pin && ext_q;
    endcase
  end
  assign tk.tick = t;
endmodule
`default_nettype wire

// ==== test/ctm_pin_model.sv ====
// Purpose: external count pin driver and wave pin load
// Assumes: pin idles low between bursts, synchronous to clk
// Notes: counts cycles where the two wave pins disagree with inversion
`timescale 1ns/1ps
`default_nettype none
module ctm_pin_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic wave,
  input wire logic wave_n,
  output logic pin,
  output var int n_bad
);
  initial begin
    pin = 1'b0;
  end
  // each pulse: one idle cycle, high two cycles, low two cycles
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (2) @(posedge clk);
      pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    if (rst) begin
      n_bad <= 0;
    end else if (wave_n !== ~wave) begin
      n_bad <= n_bad + 1;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_compact_timer_module.sv ====
// Purpose: self-checking bench for the compact timer
// Assumes: registers reached over the Avalon-MM port
// Notes: external pin ticks give exact counts
`timescale 1ns/1ps
`default_nettype none
module tb_compact_timer_module
  import ctm_pkg::*;
;
  localparam logic [4:0] A_C0 = {1'b0, CTM_OFF_CTL0};
  localparam logic [4:0] A_C1 = {1'b0, CTM_OFF_CTL1};
  localparam logic [4:0] A_DL = {1'b0, CTM_OFF_CNTL};
  localparam logic [4:0] A_AL = CTM_OFF_MATL;
  localparam logic [4:0] A_AH = CTM_OFF_MATH;
  localparam logic [2:0] sel_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  localparam int lo_tab [6] = '{14, 60, 1, 0, 7, 7};
  localparam int hi_tab [6] = '{18, 68, 3, 1, 9, 9};
  localparam logic [7:0] cm_c1 [6] = '{8'h31, 8'h19, 8'h21, 8'h29, 8'h09, 8'h25};
  localparam logic cm_i [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic cm_a [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam logic [7:0] pw_c1 [3] = '{8'h88, 8'h98, 8'hA8};
  localparam logic pw_v [3] = '{1'b0, 1'b1, 1'b1};
  logic CLK = 1'b0;
  logic RST;
  logic [4:0] ADDR;
  logic RD;
  logic WR;
  logic [31:0] WDATA;
  logic [3:0] BE;
  logic FAST;
  logic SUB;
  logic [2:0] sub_cnt;
  logic [31:0] RDATA;
  logic WAITREQ;
  logic PIN;
  logic WAVE;
  logic WAVE_N;
  logic PIRQ;
  logic MIRQ;
  int n_mismatch = 0;
  int checked = 0;
  int n_mirq = 0;
  int n_pirq = 0;
  int n_bad;
  always #12.5 CLK = ~CLK;
  // strobes for fast and sub clocks, irq pulse counters
  always @(posedge CLK) begin
    if (RST) begin
      FAST <= 1'b0;
      SUB <= 1'b0;
      sub_cnt <= 3'h0;
    end else begin
      FAST <= ~FAST;
      sub_cnt <= sub_cnt + 3'h1;
      SUB <= (sub_cnt == 3'h7);
    end
    if (MIRQ === 1'b1) n_mirq <= n_mirq + 1;
    if (PIRQ === 1'b1) n_pirq <= n_pirq + 1;
  end
  ctm_top dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(ADDR), .AVS_READ(RD), .AVS_WRITE(WR),
    .AVS_WRITEDATA(WDATA), .AVS_BYTEENABLE(BE), .AVS_READDATA(RDATA),
    .AVS_WAITREQUEST(WAITREQ), .FAST_CLK_STB(FAST), .SUB_CLK_STB(SUB),
    .EXT_COUNT_CLOCK_PIN(PIN), .WAVE_OUT_PIN(WAVE), .WAVE_OUT_INVERTED_PIN(WAVE_N),
    .PERIOD_IRQ(PIRQ), .MATCH_IRQ(MIRQ));
  ctm_pin_model pm (.clk(CLK), .rst(RST), .wave(WAVE), .wave_n(WAVE_N), .pin(PIN),
    .n_bad(n_bad));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic complete_run;
    chk({7'h0, n_bad == 0}, 8'h01, "inverse pin");
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int i;
    @(posedge CLK);
    ADDR <= a;
    WDATA <= {24'h0, d};
    WR <= w;
    RD <= ~w;
    for (i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (WAITREQ === 1'b0) break;
    end
    q = RDATA[7:0];
    if (i == 50) begin
      n_mismatch++;
      $display("BAD %0t bus timeout", $time);
      complete_run();
    end
    WR <= 1'b0;
    RD <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string m);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(q, e, m);
  endtask
  initial begin
    logic [7:0] q;
    int k;
    int k0;
    RST = 1'b1;
    ADDR = 5'h00;
    RD = 1'b0;
    WR = 1'b0;
    WDATA = 32'h0;
    BE = 4'h1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rdc(A_C0, CTM_CTL0_RST, "ctl0 rst");
    rdc(A_C1, CTM_CTL1_RST, "ctl1 rst");
    rdc(A_DL, 8'h00, "cnt rst");
    rdc(5'h18, 8'h00, "unmapped");
    wr(A_AL, 8'hA5);
    wr(A_AH, 8'hFF);
    wr(A_DL, 8'h55);
    rdc(A_AL, 8'hA5, "mat lo");
    rdc(A_AH, 8'h03, "mat hi");
    rdc(A_DL, 8'h00, "cnt ro");
    BE <= 4'h0;
    wr(A_C1, 8'hFF);
    BE <= 4'h1;
    rdc(A_C1, 8'h00, "no lane");
    wr(A_AL, 8'h00);
    wr(A_AH, 8'h00);
    wr(A_C0, 8'h68);
    pm.pulse(5);
    rdc(A_DL, 8'h05, "rise count");
    wr(A_C0, 8'hE8);
    pm.pulse(3);
    rdc(A_DL, 8'h05, "paused");
    wr(A_C0, 8'h68);
    pm.pulse(2);
    rdc(A_DL, 8'h07, "resumed");
    wr(A_C0, 8'h60);
    pm.pulse(2);
    rdc(A_DL, 8'h07, "off keeps");
    wr(A_C0, 8'h78);
    rdc(A_DL, 8'h00, "on clears");
    pm.pulse(4);
    rdc(A_DL, 8'h04, "fall count");
    for (k = 0; k < 6; k++) begin
      wr(A_C0, 8'h00);
      wr(A_C0, {1'b0, sel_tab[k], 4'h8});
      repeat (64) @(posedge CLK);
      wr(A_C0, {1'b0, sel_tab[k], 4'h0});
      acc(1'b0, A_DL, 8'h00, q);
      chk({7'h0, (q >= lo_tab[k] && q <= hi_tab[k])}, 8'h01, "clk rate");
    end
    wr(A_AL, 8'h03);
    for (k = 0; k < 6; k++) begin
      wr(A_C0, 8'h60);
      wr(A_C1, cm_c1[k]);
      wr(A_C0, 8'h68);
      repeat (3) @(posedge CLK);
      k0 = n_mirq;
      chk({7'h0, WAVE}, {7'h0, cm_i[k]}, "init lvl");
      pm.pulse(3);
      chk({7'h0, WAVE}, {7'h0, cm_a[k]}, "match out");
      rdc(A_DL, 8'h00, "match clr");
      chk(8'(n_mirq - k0), 8'h01, "match irq");
    end
    wr(A_C0, 8'h60);
    wr(A_C1, 8'h00);
    wr(A_C0, 8'h69);
    k0 = n_pirq;
    pm.pulse(127);
    rdc(A_DL, 8'h7F, "before per");
    pm.pulse(1);
    rdc(A_DL, 8'h00, "per clr");
    chk(8'(n_pirq - k0), 8'h01, "per irq");
    wr(A_C0, 8'h60);
    wr(A_C1, 8'hC1);
    wr(A_C0, 8'h68);
    k0 = n_mirq;
    pm.pulse(3);
    rdc(A_DL, 8'h00, "tmr clr");
    chk(8'(n_mirq - k0), 8'h01, "tmr irq");
    for (k = 0; k < 3; k++) begin
      wr(A_C0, 8'h60);
      wr(A_C1, pw_c1[k]);
      wr(A_C0, 8'h68);
      repeat (4) @(posedge CLK);
      chk({7'h0, WAVE}, {7'h0, pw_v[k]}, "pwm lvl");
    end
    pm.pulse(3);
    chk({7'h0, WAVE}, 8'h00, "pwm duty end");
    wr(A_C0, 8'h60);
    wr(A_C1, 8'hAA);
    wr(A_C0, 8'h69);
    pm.pulse(3);
    rdc(A_DL, 8'h00, "swap clr");
    chk({7'h0, WAVE}, 8'h01, "swap duty");
    complete_run();
  end
endmodule
`default_nettype wire
